//--- design/clcd_timer.v
`timescale 1ns/1ps
`include "clcd_defs.vh"

module clcd_timer #(
	parameter [15:0] OSC_DIV = `CLCD_OSC_DIV
) (
	input wire hclk,
	input wire hresetn,
	input wire load,
	input wire [4:0] load_ticks,
	output reg osc_tick_reg,
	output reg busy_reg
);
	reg [15:0] div_cnt_reg;
	reg [4:0] busy_cnt_reg;
	wire div_wrap;

	assign div_wrap = (div_cnt_reg == OSC_DIV - 16'h0001);

	// divider restarts on load so a busy span is whole ticks long
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg <= 16'h0000;
			osc_tick_reg <= 1'b0;
			busy_cnt_reg <= 5'h00;
			busy_reg <= 1'b0;
		end else begin
			osc_tick_reg <= div_wrap & ~load;
			if (load || div_wrap)
				div_cnt_reg <= 16'h0000;
			else
				div_cnt_reg <= div_cnt_reg + 16'h0001;
			if (load) begin
				busy_cnt_reg <= load_ticks;
				busy_reg <= (load_ticks != 5'h00);
			end else if (div_wrap && busy_cnt_reg != 5'h00) begin
				busy_cnt_reg <= busy_cnt_reg - 5'h01;
				busy_reg <= (busy_cnt_reg != 5'h01);
			end
		end
	end
endmodule // clcd_timer

//--- design/clcd_top.v
`timescale 1ns/1ps
`include "clcd_defs.vh"
// Contract
// - select low instruction path, high data path
// - 0x01 blanks display memory, address zero
// - return home zeroes address, undoes shift
// - entry mode stores step direction, shift
// - display control latches on, cursor, blink
// - shift display or move cursor, left/right
// - function set takes width, lines, font
// - glyph address set, data targets glyph memory
// - display address set, data targets display
// - instruction read gives busy and address
// - busy while executing; host waits for idle
// - data write stores byte at address
// - data read returns byte at address
// - every data access steps address counter
// - display write shifts display when shift enabled
// - blink alternates dark cell every 0.4 s

module clcd_top #(
	parameter [15:0] OSC_DIV = `CLCD_OSC_DIV,
	parameter [19:0] BLINK_TICKS = `CLCD_BLINK_TICKS
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	output reg irq,
	input wire register_select,
	input wire read_write,
	input wire enable_strobe,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe,
	output reg busy_indication,
	output reg display_on,
	output reg cursor_on,
	output reg cursor_dark,
	output reg two_lines,
	output reg font_sel,
	output reg [6:0] display_shift
);
	localparam [31:0] EXEC_T = `CLCD_EXEC_TICKS;
	localparam [31:0] CLEAR_T = `CLCD_CLEAR_TICKS;
	localparam [31:0] HOME_T = `CLCD_HOME_TICKS;

	function [6:0] ac_step;
		input [6:0] a;
		input up;
		input glyph;
		reg [6:0] r;
		begin
			r = up ? a + 7'h01 : a - 7'h01;
			if (glyph)
				r[6] = 1'b0;
			ac_step = r;
		end
	endfunction

	// pin synchronisers
	reg e_m, e_s, e_d, rs_m, rs_s, rw_m, rw_s;
	reg [7:0] db_m, db_s;
	reg cap_rs_reg, cap_rw_reg;
	reg [7:0] cap_db_reg;

	// control state
	reg [6:0] address_counter;
	reg glyph_sel_reg, inc_reg, shift_en_reg, blink_on_reg, bus_width_sel;
	reg nib_pend_reg, clearing_reg, blink_phase_reg;
	reg [3:0] nib_hi_reg;
	reg [6:0] clear_idx_reg;
	reg [19:0] blink_cnt_reg;
	reg [7:0] display_memory [0:`CLCD_DISP_DEPTH-1];
	reg [7:0] glyph_memory [0:`CLCD_GLYPH_DEPTH-1];

	// bus state
	reg wr_pend_reg, busy_d_reg;
	reg [7:0] wr_addr_reg;
	reg [`CLCD_EV_W-1:0] status_reg, mask_reg, ev_set, status_next;
	reg [31:0] state_word;

	wire osc_tick, tmr_busy, strobe_end, byte_done, busy_all;
	wire ins_wr, dat_wr, dat_rd, go_ins, go_wr, go_rd, reject;
	wire [7:0] full_byte, rd_byte;
	reg tmr_load;
	reg [4:0] tmr_ticks;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			e_m <= 1'b0;
			e_s <= 1'b0;
			e_d <= 1'b0;
			rs_m <= 1'b0;
			rs_s <= 1'b0;
			rw_m <= 1'b0;
			rw_s <= 1'b0;
			db_m <= 8'h00;
			db_s <= 8'h00;
			cap_rs_reg <= 1'b0;
			cap_rw_reg <= 1'b0;
			cap_db_reg <= 8'h00;
		end else begin
			e_m <= enable_strobe;
			e_s <= e_m;
			e_d <= e_s;
			rs_m <= register_select;
			rs_s <= rs_m;
			rw_m <= read_write;
			rw_s <= rw_m;
			db_m <= data_in;
			db_s <= db_m;
			// keep the last lines seen while enable is high; no hold after the fall needed
			if (e_s) begin
				cap_rs_reg <= rs_s;
				cap_rw_reg <= rw_s;
				cap_db_reg <= db_s;
			end
		end
	end

	assign strobe_end = e_d & ~e_s;
	assign byte_done = strobe_end & (bus_width_sel | nib_pend_reg);
	assign full_byte = bus_width_sel ? cap_db_reg : {nib_hi_reg, cap_db_reg[7:4]};
	assign busy_all = tmr_busy | clearing_reg;
	assign ins_wr = byte_done & ~cap_rs_reg & ~cap_rw_reg;
	assign dat_wr = byte_done & cap_rs_reg & ~cap_rw_reg;
	assign dat_rd = byte_done & cap_rs_reg & cap_rw_reg;
	// accesses other than the busy read are dropped while busy
	assign reject = (ins_wr | dat_wr | dat_rd) & busy_all;
	assign go_ins = ins_wr & ~busy_all;
	assign go_wr = dat_wr & ~busy_all;
	assign go_rd = dat_rd & ~busy_all;
	assign rd_byte = rs_s ? (glyph_sel_reg ? glyph_memory[address_counter[5:0]] :
		display_memory[address_counter]) : {busy_all, address_counter};

	always @* begin
		tmr_load = 1'b0;
		tmr_ticks = EXEC_T[4:0];
		if (go_wr || go_rd) begin
			tmr_load = 1'b1;
		end else if (go_ins && full_byte != 8'h00) begin
			tmr_load = 1'b1;
			if (full_byte == 8'h01)
				tmr_ticks = CLEAR_T[4:0];
			else if (full_byte[7:1] == 7'h01)
				tmr_ticks = HOME_T[4:0];
		end
	end

	clcd_timer #(
		.OSC_DIV(OSC_DIV)
	) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(tmr_load),
		.load_ticks(tmr_ticks),
		.osc_tick_reg(osc_tick),
		.busy_reg(tmr_busy)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			address_counter <= 7'h00;
			glyph_sel_reg <= 1'b0;
			inc_reg <= 1'b1;
			shift_en_reg <= 1'b0;
			display_on <= 1'b0;
			cursor_on <= 1'b0;
			blink_on_reg <= 1'b0;
			bus_width_sel <= 1'b1;
			two_lines <= 1'b0;
			font_sel <= 1'b0;
			display_shift <= 7'h00;
			nib_pend_reg <= 1'b0;
			nib_hi_reg <= 4'h0;
			clearing_reg <= 1'b0;
			clear_idx_reg <= 7'h00;
		end else begin
			if (strobe_end && !bus_width_sel) begin
				nib_pend_reg <= ~nib_pend_reg;
				if (!nib_pend_reg)
					nib_hi_reg <= cap_db_reg[7:4];
			end
			if (clearing_reg) begin
				clear_idx_reg <= clear_idx_reg + 7'h01;
				if (clear_idx_reg == 7'h7f)
					clearing_reg <= 1'b0;
			end
			if (go_ins) begin
				casez (full_byte)
				8'b1???????: begin
					address_counter <= full_byte[6:0];
					glyph_sel_reg <= 1'b0;
				end
				8'b01??????: begin
					address_counter <= {1'b0, full_byte[5:0]};
					glyph_sel_reg <= 1'b1;
				end
				8'b001?????: begin
					bus_width_sel <= full_byte[4];
					two_lines <= full_byte[3];
					font_sel <= full_byte[2];
					nib_pend_reg <= 1'b0;
				end
				8'b0001????: begin
					if (full_byte[3])
						display_shift <= full_byte[2] ? display_shift - 7'h01 :
							display_shift + 7'h01;
					else
						address_counter <= ac_step(address_counter, full_byte[2],
							glyph_sel_reg);
				end
				8'b00001???: begin
					display_on <= full_byte[2];
					cursor_on <= full_byte[1];
					blink_on_reg <= full_byte[0];
				end
				8'b000001??: begin
					inc_reg <= full_byte[1];
					shift_en_reg <= full_byte[0];
				end
				8'b0000001?: begin
					address_counter <= 7'h00;
					glyph_sel_reg <= 1'b0;
					display_shift <= 7'h00;
				end
				8'b00000001: begin
					address_counter <= 7'h00;
					glyph_sel_reg <= 1'b0;
					display_shift <= 7'h00;
					clearing_reg <= 1'b1;
					clear_idx_reg <= 7'h00;
				end
				default: begin
				end
				endcase
			end
			if (go_wr || go_rd)
				address_counter <= ac_step(address_counter, inc_reg, glyph_sel_reg);
			// increment moves the picture left, so the offset grows
			if (go_wr && shift_en_reg && !glyph_sel_reg)
				display_shift <= inc_reg ? display_shift + 7'h01 :
					display_shift - 7'h01;
		end
	end

	// storage has no reset; read before write returns unknown contents
	always @(posedge hclk) begin
		if (clearing_reg)
			display_memory[clear_idx_reg] <= `CLCD_BLANK_CHAR;
		else if (go_wr && !glyph_sel_reg)
			display_memory[address_counter] <= full_byte;
		if (go_wr && glyph_sel_reg)
			glyph_memory[address_counter[5:0]] <= full_byte;
	end

	// read drive and blink
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
			blink_cnt_reg <= 20'h00000;
			blink_phase_reg <= 1'b0;
			cursor_dark <= 1'b0;
			busy_indication <= 1'b0;
		end else begin
			data_oe <= e_s & rw_s;
			if (bus_width_sel)
				data_out <= rd_byte;
			else if (!nib_pend_reg)
				data_out <= {rd_byte[7:4], 4'h0};
			else
				data_out <= {rd_byte[3:0], 4'h0};
			if (osc_tick) begin
				if (blink_cnt_reg == BLINK_TICKS - 20'h00001) begin
					blink_cnt_reg <= 20'h00000;
					blink_phase_reg <= ~blink_phase_reg;
				end else begin
					blink_cnt_reg <= blink_cnt_reg + 20'h00001;
				end
			end
			cursor_dark <= blink_on_reg & blink_phase_reg & display_on;
			busy_indication <= busy_all;
		end
	end

	// bus registers: zero wait state, read data loaded in the address phase
	always @* begin
		ev_set = `CLCD_EV_RESET;
		ev_set[`CLCD_EV_DONE] = busy_d_reg & ~busy_all;
		ev_set[`CLCD_EV_REJECT] = reject;
		ev_set[`CLCD_EV_MODE] = go_ins & (full_byte[7:5] == 3'b001);
		ev_set[`CLCD_EV_WRITE] = go_wr;
		status_next = status_reg;
		if (wr_pend_reg && wr_addr_reg == `CLCD_OFS_STATUS)
			status_next = status_reg & ~hwdata[`CLCD_EV_W-1:0];
		// an event in the clearing cycle survives
		status_next = status_next | ev_set;
		state_word = 32'h00000000;
		state_word[`CLCD_ST_AC_LSB+6:`CLCD_ST_AC_LSB] = address_counter;
		state_word[`CLCD_ST_BUSY] = busy_all;
		state_word[`CLCD_ST_DISP] = display_on;
		state_word[`CLCD_ST_CURSOR] = cursor_on;
		state_word[`CLCD_ST_BLINK] = blink_on_reg;
		state_word[`CLCD_ST_INC] = inc_reg;
		state_word[`CLCD_ST_SHIFT] = shift_en_reg;
		state_word[`CLCD_ST_WIDTH8] = bus_width_sel;
		state_word[`CLCD_ST_LINES] = two_lines;
		state_word[`CLCD_ST_FONT] = font_sel;
		state_word[`CLCD_ST_GLYPH] = glyph_sel_reg;
		state_word[`CLCD_ST_DARK] = blink_phase_reg;
		state_word[`CLCD_ST_NIBBLE] = nib_pend_reg;
		state_word[`CLCD_ST_OFS_LSB+6:`CLCD_ST_OFS_LSB] = display_shift;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			irq <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			status_reg <= `CLCD_EV_RESET;
			mask_reg <= `CLCD_EV_RESET;
			busy_d_reg <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			busy_d_reg <= busy_all;
			status_reg <= status_next;
			if (wr_pend_reg && wr_addr_reg == `CLCD_OFS_MASK)
				mask_reg <= hwdata[`CLCD_EV_W-1:0];
			irq <= |(status_next & mask_reg);
			wr_pend_reg <= hsel & htrans[1] & hready & hwrite;
			wr_addr_reg <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite) begin
				case (haddr[7:0])
				`CLCD_OFS_STATUS: hrdata <= {28'h0000000, status_reg};
				`CLCD_OFS_MASK: hrdata <= {28'h0000000, mask_reg};
				`CLCD_OFS_STATE: hrdata <= state_word;
				default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // clcd_top

//--- dv/clcd_host_model.sv
`timescale 1ns/1ps
module clcd_host_model (
	input wire hclk,
	output logic register_select,
	output logic read_write,
	output logic enable_strobe,
	output logic [7:0] data_in,
	input wire [7:0] data_out
);
	initial begin
		register_select = 1'b0;
		read_write = 1'b0;
		enable_strobe = 1'b0;
		data_in = 8'h00;
	end
	// lines settle one edge ahead and stay put through the strobe
	task xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge hclk);
		register_select <= rs;
		read_write <= rw;
		data_in <= d;
		@(posedge hclk);
		enable_strobe <= 1'b1;
		repeat (6) @(posedge hclk);
		q = data_out;
		enable_strobe <= 1'b0;
		data_in <= ~d; // released bus never shows the old byte
		repeat (5) @(posedge hclk);
	endtask
endmodule // clcd_host_model

//--- dv/clcd_properties.sv
`timescale 1ns/1ps
module clcd_properties #(
	parameter [15:0] OSC_DIV = 16'h320,
	parameter [19:0] BLINK_TICKS = 20'h186a0
) (
	input wire hclk,
	input wire hresetn,
	input wire read_write,
	input wire enable_strobe,
	input wire data_oe,
	input wire busy_indication,
	input wire display_on,
	input wire cursor_dark,
	input wire two_lines,
	input wire font_sel,
	input wire [6:0] display_shift
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_oe_cause: assert property (
		$rose(data_oe) |-> $past(enable_strobe) && $past(read_write)) else $error("oe no strobe");
	a_oe_drops: assert property (
		!enable_strobe [*5] |-> !data_oe) else $error("oe stuck");
	a_busy_min: assert property (
		$rose(busy_indication) |-> busy_indication [*8]) else $error("busy short");
	a_busy_ends: assert property (
		busy_indication |-> ##[1:400] !busy_indication) else $error("busy stuck");
	a_dark_disp: assert property (
		cursor_dark |-> display_on || $past(display_on)) else $error("dark while off");
	a_shift_busy: assert property (
		$changed(display_shift) |-> ##[0:4] busy_indication) else $error("shift idle");
	a_ctrl_busy: assert property (
		$changed(display_on) |-> ##[0:4] busy_indication) else $error("ctrl idle");
	a_func_busy: assert property (
		$changed({two_lines, font_sel}) |-> ##[0:4] busy_indication) else $error("func idle");
endmodule // clcd_properties
bind clcd_top clcd_properties #(.OSC_DIV(OSC_DIV), .BLINK_TICKS(BLINK_TICKS)) u_props (
	.hclk, .hresetn, .read_write, .enable_strobe, .data_oe, .busy_indication,
	.display_on, .cursor_dark, .two_lines, .font_sel, .display_shift);

//--- dv/tb_char_lcd_instruction_port.sv
`timescale 1ns/1ps
`include "clcd_defs.vh"
module tb_char_lcd_instruction_port;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] r;
	logic [7:0] q;
	logic [7:0] v;
	int bad_count = 0;
	int check_count = 0;
	wire hreadyout, hresp, irq, data_oe, busy_indication, display_on, cursor_on;
	wire cursor_dark, two_lines, font_sel, register_select, read_write, enable_strobe;
	wire [31:0] hrdata;
	wire [7:0] data_out;
	wire [7:0] data_in;
	wire [6:0] display_shift;
	always #2.5 hclk = ~hclk;
	clcd_top #(.OSC_DIV(16'h4), .BLINK_TICKS(20'h3)) u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .register_select,
		.read_write, .enable_strobe, .data_in, .data_out, .data_oe, .busy_indication,
		.display_on, .cursor_on, .cursor_dark, .two_lines, .font_sel, .display_shift);
	clcd_host_model u_host (.hclk, .register_select, .read_write, .enable_strobe,
		.data_in, .data_out);
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task abort;
		bad_count++;
		tally_and_finish();
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task hold;
		@(posedge hclk);
		for (int n = 0; n < 20 && hreadyout !== 1'b1; n++)
			@(posedge hclk);
		if (hreadyout !== 1'b1)
			abort();
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hold();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		hold();
		r = hrdata;
	endtask
	// busy read leaves the address counter in q
	task idle;
		for (int n = 0; n < 40; n++) begin
			u_host.xfer(1'b0, 1'b1, 8'h00, q);
			if (q[7] === 1'b0)
				return;
		end
		abort();
	endtask
	task ins(input logic [7:0] b);
		u_host.xfer(1'b0, 1'b0, b, q);
		idle();
	endtask
	task dat(input logic rw, input logic [7:0] d);
		u_host.xfer(1'b1, rw, d, v);
		idle();
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 8'h00, 32'h0);
		chk("status", 32'h0, r);
		chk("resp", 32'h0, hresp);
		ahb(1'b0, 8'h08, 32'h0);
		chk("state", 32'h2800, r);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, r);
		ahb(1'b1, 8'h04, 32'hf);
		ahb(1'b0, 8'h04, 32'h0);
		chk("mask", 32'hf, r);
		ins(8'h38);
		chk("func", 32'h2, {two_lines, font_sel});
		chk("irq", 32'h1, irq);
		ahb(1'b1, 8'h00, 32'hf);
		ahb(1'b1, 8'h04, 32'h0);
		chk("irq clear", 32'h0, irq);
		ins(8'h0f);
		chk("irq masked", 32'h0, irq);
		chk("disp", 32'h3, {display_on, cursor_on});
		for (int i = 0; i < 100 && cursor_dark !== 1'b1; i++)
			@(posedge hclk);
		chk("dark", 32'h1, cursor_dark);
		ins(8'h01);
		chk("clr addr", 32'h0, q);
		dat(1'b1, 8'h00);
		chk("blank", `CLCD_BLANK_CHAR, v);
		ins(8'h06);
		ins(8'h85);
		chk("dd addr", 32'h5, q);
		dat(1'b0, 8'h41);
		dat(1'b0, 8'h42);
		chk("step up", 32'h7, q);
		ins(8'h85);
		dat(1'b1, 8'h00);
		chk("rd a", 32'h41, v);
		ins(8'h04);
		dat(1'b1, 8'h00);
		chk("rd b", 32'h542, {q[6:0], v});
		ins(8'h40);
		dat(1'b0, 8'h15);
		chk("cg wrap", 32'h3f, q);
		ins(8'h40);
		dat(1'b1, 8'h00);
		chk("cg rd", 32'h15, v);
		ins(8'h07);
		ins(8'h80);
		dat(1'b0, 8'h55);
		dat(1'b1, 8'h00);
		chk("shift wr", 32'h1, display_shift);
		ins(8'h18);
		chk("shift l", 32'h2, display_shift);
		ins(8'h1c);
		chk("shift r", 32'h1, display_shift);
		ins(8'h02);
		chk("home", 32'h0, {q, display_shift});
		ins(8'h14);
		chk("cursor r", 32'h1, {display_shift, q});
		u_host.xfer(1'b0, 1'b0, 8'h08, q);
		u_host.xfer(1'b0, 1'b0, 8'h0c, q);
		idle();
		chk("refused", 32'h0, {display_on, cursor_dark});
		ahb(1'b0, 8'h00, 32'h0);
		chk("reject", 32'h1, r[1]);
		u_host.xfer(1'b0, 1'b0, 8'h28, q);
		repeat (60) @(posedge hclk);
		u_host.xfer(1'b0, 1'b0, 8'h90, q);
		u_host.xfer(1'b0, 1'b0, 8'h20, q);
		repeat (60) @(posedge hclk);
		u_host.xfer(1'b0, 1'b1, 8'h00, q);
		chk("nib hi", 32'h10, q);
		u_host.xfer(1'b0, 1'b1, 8'h00, q);
		chk("nib lo", 32'h20, q);
		tally_and_finish();
	end
endmodule // tb_char_lcd_instruction_port

//--- shared/clcd_defs.vh
`ifndef CLCD_DEFS_VH
`define CLCD_DEFS_VH

// clock and internal oscillator rates
`define CLCD_CLK_HZ 200000000
`define CLCD_OSC_HZ 250000
// clock over oscillator rate, sized to the divider parameter
`define CLCD_OSC_DIV 16'h0320

// execution times in microseconds, tick counts rounded up
`define CLCD_T_EXEC_US 40
`define CLCD_T_CLEAR_US 82
`define CLCD_T_HOME_US 40
`define CLCD_EXEC_TICKS ((`CLCD_T_EXEC_US * `CLCD_OSC_HZ + 999999) / 1000000)
`define CLCD_CLEAR_TICKS ((`CLCD_T_CLEAR_US * `CLCD_OSC_HZ + 999999) / 1000000)
`define CLCD_HOME_TICKS ((`CLCD_T_HOME_US * `CLCD_OSC_HZ + 999999) / 1000000)

// blink half period in milliseconds, counted in oscillator ticks
`define CLCD_T_BLINK_MS 400
// 400 ms of ticks, sized to the blink counter
`define CLCD_BLINK_TICKS 20'h186a0

// memory sizes and blank code
`define CLCD_DISP_DEPTH 128
`define CLCD_GLYPH_DEPTH 64
`define CLCD_BLANK_CHAR 8'h20

// bus register offsets
`define CLCD_OFS_STATUS 8'h00
`define CLCD_OFS_MASK 8'h04
`define CLCD_OFS_STATE 8'h08

// status and mask bits
`define CLCD_EV_W 4
`define CLCD_EV_DONE 0
`define CLCD_EV_REJECT 1
`define CLCD_EV_MODE 2
`define CLCD_EV_WRITE 3
`define CLCD_EV_RESET 4'h0

// state register fields
`define CLCD_ST_AC_LSB 0
`define CLCD_ST_BUSY 7
`define CLCD_ST_DISP 8
`define CLCD_ST_CURSOR 9
`define CLCD_ST_BLINK 10
`define CLCD_ST_INC 11
`define CLCD_ST_SHIFT 12
`define CLCD_ST_WIDTH8 13
`define CLCD_ST_LINES 14
`define CLCD_ST_FONT 15
`define CLCD_ST_GLYPH 16
`define CLCD_ST_DARK 17
`define CLCD_ST_NIBBLE 18
`define CLCD_ST_OFS_LSB 24

`endif
